// [hw/chgst_bank.sv]
// read-only charger status bank: three status registers and their read port
// ----------------------------------------------------------------
// Summary of operation
// - phase field bits 7:5: 1 trickle, 2 pre, 3 fast, 4 taper
// - phase reads 0 idle, 6 top-off, 7 done; code 5 never shown
// - source field bits 4:1 gives detected port or adapter type code
// - source reads 7 in otg, b direct from bus, c in backup
// - source reads 0 with no input (unless otg, backup or direct) or otg blocked by hot/cold battery
// - bit 0 of first register set once port detection completed
// - optimizer state bits 7:6 of second register, code 3 never shown
// - bit 2 of second register set during die thermal regulation
// - bit 1 of second register set only while data-line detect runs
// - bit 0 of second register set while battery above uvlo level
// - third register bits 7 and 6 show second and first fet pair
// - third register bit 5 set on conversion done, one-shot mode only
// - bit 4 set in forward mode while system held at minimum
// - bit 3 of third register set when fast charge timer expired
// - bit 2 of third register set when trickle timer expired
// - otg hot limit selectable or disabled; cold limit selectable
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "chgst_cfg.svh"

module chgst_bank (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire chgst_pkg::chgst_core_s core,
	input wire chgst_pkg::chgst_rd_s rd_req,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q
);
	import chgst_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic src_valid(input logic [3:0] code);
		src_valid = (code != `CHGST_SRC_NONE) && (code <= `CHGST_SRC_NONSTD);
		src_valid = src_valid || (code == `CHGST_SRC_NOTQUAL);
	endfunction

	function automatic logic phase_valid(input logic [2:0] code);
		phase_valid = (code != `CHGST_PH_RSVD);
	endfunction

	// ----------------------------------------------------------------
	// otg temperature block
	// ----------------------------------------------------------------
	logic signed [7:0] hot_lim;
	logic signed [7:0] cold_lim;
	logic otg_blocked;

	always_comb begin
		case (core.hot_limit_sel)
			2'h0: hot_lim = `CHGST_HOT_55;
			2'h1: hot_lim = `CHGST_HOT_60;
			default: hot_lim = `CHGST_HOT_65;
		endcase
		cold_lim = core.cold_limit_sel ? `CHGST_COLD_M20 : `CHGST_COLD_M10;
		otg_blocked = (core.batt_temp <= cold_lim) ||
			((core.hot_limit_sel != `CHGST_HOT_DISABLE) &&
			(core.batt_temp >= hot_lim));
	end

	// ----------------------------------------------------------------
	// first register: phase and source
	// ----------------------------------------------------------------
	logic [2:0] phase_q;
	logic [3:0] src_d;
	logic [3:0] src_q;

	// a reserved phase from the core is shown as idle, never passed out
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phase_q <= `CHGST_PH_IDLE;
		end else if (phase_valid(core.phase)) begin
			phase_q <= core.phase;
		end else begin
			phase_q <= `CHGST_PH_IDLE;
		end
	end

	always_comb begin
		if (core.otg_mode) begin
			src_d = otg_blocked ? `CHGST_SRC_NONE : `CHGST_SRC_OTG;
		end else if (core.backup_mode) begin
			src_d = `CHGST_SRC_BACKUP;
		end else if (core.direct_bus) begin
			src_d = `CHGST_SRC_DIRECT;
		end else if (!core.input_present) begin
			src_d = `CHGST_SRC_NONE;
		end else if (src_valid(core.source_det)) begin
			src_d = core.source_det;
		end else begin
			// reserved detector output is reported as unknown adapter
			src_d = `CHGST_SRC_UNKNOWN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			src_q <= `CHGST_SRC_NONE;
		end else begin
			src_q <= src_d;
		end
	end

	// ----------------------------------------------------------------
	// port detection sequence
	// ----------------------------------------------------------------
	chgst_det_e det_q;

	// losing the input restarts detection from scratch
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !core.input_present) begin
			det_q <= CHGST_DET_IDLE;
		end else begin
			case (det_q)
				CHGST_DET_IDLE: begin
					if (core.det_start) begin
						det_q <= CHGST_DET_BUSY;
					end
				end
				CHGST_DET_BUSY: begin
					if (core.det_done) begin
						det_q <= CHGST_DET_DONE;
					end
				end
				CHGST_DET_DONE: begin
					if (core.det_start) begin
						det_q <= CHGST_DET_BUSY;
					end
				end
				default: det_q <= CHGST_DET_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// second register: optimizer, thermal, battery
	// ----------------------------------------------------------------
	logic [1:0] opt_q;
	logic therm_q;
	logic vbat_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			opt_q <= `CHGST_OPT_OFF;
		end else if (core.opt_state == `CHGST_OPT_RSVD) begin
			opt_q <= `CHGST_OPT_OFF;
		end else begin
			opt_q <= core.opt_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			therm_q <= 1'b0;
			vbat_q <= 1'b0;
		end else begin
			therm_q <= core.die_hot;
			vbat_q <= core.vbat_above_uvlo;
		end
	end

	// ----------------------------------------------------------------
	// third register: fets, conversion, min system, timers
	// ----------------------------------------------------------------
	logic [1:0] fet_q;
	logic adc_q;
	logic minsys_q;
	logic fast_q;
	logic trickle_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fet_q <= 2'h0;
			minsys_q <= 1'b0;
			fast_q <= 1'b0;
			trickle_q <= 1'b0;
		end else begin
			fet_q <= {core.fet2_placed, core.fet1_placed};
			minsys_q <= core.forward_mode && core.vbat_below_min;
			fast_q <= core.fast_tmr_exp;
			trickle_q <= core.trickle_tmr_exp;
		end
	end

	// completion held until the next start; a done in the same cycle wins
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !core.adc_oneshot) begin
			adc_q <= 1'b0;
		end else if (core.adc_done) begin
			adc_q <= 1'b1;
		end else if (core.adc_start) begin
			adc_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register images and read port
	// ----------------------------------------------------------------
	chgst_byte_t img_phase_src;
	chgst_byte_t img_opt_therm;
	chgst_byte_t img_path_tmr;

	always_comb begin
		img_phase_src = `CHGST_RST_VAL;
		img_phase_src[`CHGST_PHASE_MSB:`CHGST_PHASE_LSB] = phase_q;
		img_phase_src[`CHGST_SRC_MSB:`CHGST_SRC_LSB] = src_q;
		img_phase_src[`CHGST_DET_DONE_BIT] = (det_q == CHGST_DET_DONE);
		img_opt_therm = `CHGST_RST_VAL;
		img_opt_therm[`CHGST_OPT_MSB:`CHGST_OPT_LSB] = opt_q;
		img_opt_therm[`CHGST_THERM_BIT] = therm_q;
		img_opt_therm[`CHGST_DET_BUSY_BIT] = (det_q == CHGST_DET_BUSY);
		img_opt_therm[`CHGST_VBAT_BIT] = vbat_q;
		img_path_tmr = `CHGST_RST_VAL;
		img_path_tmr[`CHGST_FET2_BIT] = fet_q[1];
		img_path_tmr[`CHGST_FET1_BIT] = fet_q[0];
		img_path_tmr[`CHGST_ADC_BIT] = adc_q;
		img_path_tmr[`CHGST_MINSYS_BIT] = minsys_q;
		img_path_tmr[`CHGST_FAST_TMR_BIT] = fast_q;
		img_path_tmr[`CHGST_TRICKLE_TMR_BIT] = trickle_q;
	end

	// no write path exists, so nothing the host sends can alter a field
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_data_q <= `CHGST_RST_VAL;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req.rd_en;
			if (rd_req.rd_en) begin
				case (rd_req.addr)
					`CHGST_OFS_PHASE_SRC: rd_data_q <= img_phase_src;
					`CHGST_OFS_OPT_THERM: rd_data_q <= img_opt_therm;
					`CHGST_OFS_PATH_TMR: rd_data_q <= img_path_tmr;
					default: rd_data_q <= `CHGST_RST_VAL;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_det_started;
		det_q == CHGST_DET_IDLE && core.det_start && core.input_present;
	endsequence
	sequence s_det_finished;
		det_q == CHGST_DET_BUSY && core.det_done && core.input_present;
	endsequence

	AST_PHASE_TRACK: assert property (
		core.phase != `CHGST_PH_RSVD |=> phase_q == $past(core.phase))
		else $error("phase field does not follow core");
	AST_PHASE_NO_RSVD: assert property (
		rd_valid_q && $past(rd_req.addr) == `CHGST_OFS_PHASE_SRC |->
		rd_data_q[7:5] != `CHGST_PH_RSVD)
		else $error("reserved phase code read back");
	AST_SRC_DET: assert property (
		core.input_present && !core.otg_mode && !core.backup_mode &&
		!core.direct_bus && src_valid(core.source_det) |=>
		src_q == $past(core.source_det))
		else $error("detected source not reported");
	AST_SRC_OTG: assert property (
		core.otg_mode && !otg_blocked |=> src_q == `CHGST_SRC_OTG)
		else $error("otg code missing");
	AST_SRC_BLOCK: assert property (
		core.otg_mode && otg_blocked |=> src_q == `CHGST_SRC_NONE)
		else $error("blocked otg not reported as zero");
	AST_DET_DONE: assert property (
		s_det_finished |=>
		img_phase_src[`CHGST_DET_DONE_BIT] && !img_opt_therm[1])
		else $error("detection completion not shown");
	AST_DET_BUSY: assert property (
		s_det_started |=> img_opt_therm[`CHGST_DET_BUSY_BIT] &&
		!img_phase_src[`CHGST_DET_DONE_BIT])
		else $error("detection busy flag not set");
	AST_OPT: assert property (
		core.opt_state != `CHGST_OPT_RSVD |=>
		opt_q == $past(core.opt_state))
		else $error("optimizer state wrong");
	AST_OPT_NO_RSVD: assert property (
		core.opt_state == `CHGST_OPT_RSVD |=> opt_q == `CHGST_OPT_OFF)
		else $error("reserved optimizer code shown");
	AST_THERM_VBAT: assert property (
		##1 therm_q == $past(core.die_hot) &&
		vbat_q == $past(core.vbat_above_uvlo))
		else $error("thermal or battery flag stale");
	AST_MINSYS: assert property (
		!core.forward_mode |=> !minsys_q)
		else $error("min system flag outside forward mode");
	AST_ADC_HOLD: assert property (
		core.adc_oneshot && core.adc_done ##1 core.adc_oneshot &&
		!core.adc_start [*2] |=> adc_q)
		else $error("conversion flag lost");
	AST_RSVD_ZERO: assert property (
		rd_valid_q && $past(rd_req.addr) == `CHGST_OFS_OPT_THERM |->
		rd_data_q[5:3] == 3'h0)
		else $error("reserved bits not zero");
endmodule

// [shared/chgst_cfg.svh]
// register offsets, field positions, codes and limits of the status bank
`ifndef CHGST_CFG_SVH
`define CHGST_CFG_SVH
`define CHGST_OFS_PHASE_SRC 8'h1c
`define CHGST_OFS_OPT_THERM 8'h1d
`define CHGST_OFS_PATH_TMR 8'h1e
`define CHGST_RST_VAL 8'h00
// first register
`define CHGST_PHASE_MSB 7
`define CHGST_PHASE_LSB 5
`define CHGST_SRC_MSB 4
`define CHGST_SRC_LSB 1
`define CHGST_DET_DONE_BIT 0
// second register
`define CHGST_OPT_MSB 7
`define CHGST_OPT_LSB 6
`define CHGST_THERM_BIT 2
`define CHGST_DET_BUSY_BIT 1
`define CHGST_VBAT_BIT 0
// third register
`define CHGST_FET2_BIT 7
`define CHGST_FET1_BIT 6
`define CHGST_ADC_BIT 5
`define CHGST_MINSYS_BIT 4
`define CHGST_FAST_TMR_BIT 3
`define CHGST_TRICKLE_TMR_BIT 2
// charge phase codes
`define CHGST_PH_IDLE 3'h0
`define CHGST_PH_RSVD 3'h5
// input source codes
`define CHGST_SRC_NONE 4'h0
`define CHGST_SRC_UNKNOWN 4'h5
`define CHGST_SRC_NONSTD 4'h6
`define CHGST_SRC_OTG 4'h7
`define CHGST_SRC_NOTQUAL 4'h8
`define CHGST_SRC_DIRECT 4'hb
`define CHGST_SRC_BACKUP 4'hc
// optimizer codes
`define CHGST_OPT_OFF 2'h0
`define CHGST_OPT_RSVD 2'h3
// battery temperature limits in degrees celsius
`define CHGST_HOT_55 8'sd55
`define CHGST_HOT_60 8'sd60
`define CHGST_HOT_65 8'sd65
`define CHGST_HOT_DISABLE 2'h3
`define CHGST_COLD_M10 (-8'sd10)
`define CHGST_COLD_M20 (-8'sd20)
`endif

// [shared/chgst_pkg.sv]
// types of the charger status bank
package chgst_pkg;
	typedef logic [7:0] chgst_byte_t;
	typedef enum logic [2:0] {
		CHGST_DET_IDLE = 3'b001,
		CHGST_DET_BUSY = 3'b010,
		CHGST_DET_DONE = 3'b100
	} chgst_det_e;
	// live state from the charger core
	typedef struct packed {
		logic [2:0] phase;
		logic input_present;
		logic [3:0] source_det;
		logic otg_mode;
		logic backup_mode;
		logic direct_bus;
		logic det_start;
		logic det_done;
		logic [1:0] opt_state;
		logic die_hot;
		logic vbat_above_uvlo;
		logic fet2_placed;
		logic fet1_placed;
		logic adc_oneshot;
		logic adc_start;
		logic adc_done;
		logic forward_mode;
		logic vbat_below_min;
		logic fast_tmr_exp;
		logic trickle_tmr_exp;
		logic signed [7:0] batt_temp;
		logic [1:0] hot_limit_sel;
		logic cold_limit_sel;
	} chgst_core_s;
	// host register read port
	typedef struct packed {
		logic rd_en;
		logic [7:0] addr;
	} chgst_rd_s;
endpackage

// [tb/chgst_bank_test.sv]
// self-checking bench of the charger status bank with a host reader
`timescale 1ns/1ps
module chgst_bank_test;
	import chgst_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	chgst_core_s core = '0;
	chgst_rd_s rd_req;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int det = 0;
	logic adc = 1'b0;
	logic was_one = 1'b0;
	integer seed = 32'h80a7;
	// 55 54 60 59 65 64 -10 -9 -20 -21: both sides of every limit
	logic signed [7:0] temps [10] = '{8'h37, 8'h36, 8'h3c, 8'h3b, 8'h41,
		8'h40, 8'hf6, 8'hf7, 8'hec, 8'heb};

	always #2.5 clk_sys = ~clk_sys;

	chgst_bank chgst_bank_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.core(core), .rd_req(rd_req), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q));
	chgst_host chgst_host_i (.clk_sys(clk_sys), .rd_req(rd_req),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_reg(chgst_core_s c, logic [7:0] a);
		logic [3:0] s;
		logic signed [7:0] hot;
		logic blk;
		hot = (c.hot_limit_sel == 2'h0) ? 8'sh37 :
			(c.hot_limit_sel == 2'h1) ? 8'sh3c : 8'sh41;
		blk = (c.batt_temp <= (c.cold_limit_sel ? 8'shec : 8'shf6)) ||
			(c.hot_limit_sel != 2'h3 && c.batt_temp >= hot);
		if (c.otg_mode) s = blk ? 4'h0 : 4'h7;
		else if (c.backup_mode) s = 4'hc;
		else if (c.direct_bus) s = 4'hb;
		else if (!c.input_present) s = 4'h0;
		else if (c.source_det inside {[4'h1:4'h6], 4'h8}) s = c.source_det;
		else s = 4'h5;
		case (a)
		8'h1c: return {(c.phase == 3'h5) ? 3'h0 : c.phase, s, det == 2};
		8'h1d: return {(c.opt_state == 2'h3) ? 2'h0 : c.opt_state, 3'h0,
			c.die_hot, det == 1, c.vbat_above_uvlo};
		8'h1e: return {c.fet2_placed, c.fet1_placed, adc,
			c.forward_mode & c.vbat_below_min, c.fast_tmr_exp,
			c.trickle_tmr_exp, 2'h0};
		default: return 8'h00;
		endcase
	endfunction

	task automatic check_byte(string what, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rd_chk(logic [7:0] a, chgst_core_s c);
		logic [7:0] d;
		logic ok;
		chgst_host_i.host_read(a, d, ok);
		check_byte("read valid pulse", 8'h01, {7'h0, ok});
		check_byte($sformatf("register %h", a), exp_reg(c, a), d);
	endtask

	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// core held at zero so the flops cannot refill during the check
	task automatic reset_check();
		logic [7:0] a;
		core <= '0;
		sys_rst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		det = 0;
		adc = 1'b0;
		was_one = 1'b0;
		@(posedge clk_sys);
		for (a = 8'h1c; a <= 8'h1e; a++) begin
			rd_chk(a, '0);
		end
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [63:0] r;
		chgst_core_s c;
		int i;
		reset_check();
		for (i = 0; i < 300; i++) begin
			r = {$random(seed), $random(seed)};
			c = r[36:0];
			c.otg_mode &= r[50];
			c.backup_mode &= r[51];
			c.direct_bus &= r[52];
			c.batt_temp = temps[r[59:56] % 10];
			// detection pulses only where the next state is unambiguous
			c.det_start = c.input_present && det != 1 && r[53];
			c.det_done = c.input_present && det == 1 && r[53];
			c.adc_start = c.adc_oneshot && (!was_one || r[55]);
			c.adc_done = r[54] && !(c.adc_oneshot && !was_one);
			det = !c.input_present ? 0 : c.det_start ? 1 :
				c.det_done ? 2 : det;
			adc = !c.adc_oneshot ? 1'b0 : c.adc_done ? 1'b1 :
				c.adc_start ? 1'b0 : adc;
			was_one = c.adc_oneshot;
			core <= c;
			@(posedge clk_sys);
			c.det_start = 1'b0;
			c.det_done = 1'b0;
			c.adc_start = 1'b0;
			c.adc_done = 1'b0;
			core <= c;
			@(posedge clk_sys);
			rd_chk(8'h1c, c);
			rd_chk(8'h1d, c);
			rd_chk(8'h1e, c);
			rd_chk(r[62] ? 8'h1f : 8'h1b, c);
		end
		reset_check();
		complete_run();
	end
endmodule

// [tb/chgst_host.sv]
// host model: issues single reads on the status bank's read port
`timescale 1ns/1ps
module chgst_host (
	input wire logic clk_sys,
	output chgst_pkg::chgst_rd_s rd_req,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q
);
	import chgst_pkg::*;
	initial rd_req = '0;
	// ----------------------------------------------------------------
	// read task
	// ----------------------------------------------------------------
	// request held for the taking edge only; ok needs a one-cycle valid
	task automatic host_read(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		rd_req <= '{rd_en: 1'b1, addr: a};
		@(posedge clk_sys);
		rd_req <= '0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge clk_sys);
			ok = (rd_valid_q === 1'b1);
		end
		d = rd_data_q;
		@(posedge clk_sys);
		ok = ok && (rd_valid_q === 1'b0);
	endtask
endmodule
